// ### common/dptl_regs.svh
/*
 * Fixed figures of the digital phase tracking loop: clock rates, time code
 * division, phase register scale, update positions and multiplex timing.
 * Assumes inclusion by bare name from the design files; definitions only.
 */
`ifndef DPTL_REGS_SVH
`define DPTL_REGS_SVH

`define DPTL_CLK_HZ 50000000
`define DPTL_TICK_HZ 1020000
`define DPTL_RATE_GCD 10000
`define DPTL_TC_DIV 100
`define DPTL_PH_MOD 100000
`define DPTL_PH_DIGIT 1000
`define DPTL_ADD_POS 99
`define DPTL_DIFF_POS 0
`define DPTL_SLOT_TC 1020
`define DPTL_NUM_SLOTS 8
`define DPTL_SLOT_A 0
`define DPTL_SLOT_B 1
`define DPTL_RST_VAL 0

`endif

// ### common/dptl_pkg.sv
/*
 * Types shared by the tracking loop and its time code generator.
 * Assumes no other package; numbers live in dptl_regs.svh.
 */
package dptl_pkg;
	typedef logic [16:0] dptl_phase_t;
	typedef logic [6:0] dptl_pos_t;
	typedef enum logic [1:0] {
		DPTL_DF_IDLE,
		DPTL_DF_CLEAR,
		DPTL_DF_ADD,
		DPTL_DF_SUB
	} dptl_diff_step_t;
endpackage

// ### src/dptl_timecode.sv
/*
 * Time code generator: derives the 1.02 MHz clock pulse enable from sys_clk,
 * divides it into the time code cycle and produces the multiplex waveforms.
 * Assumes a single sys_clk domain with synchronous active-low reset.
 */
`timescale 1ns/1ps
`include "dptl_regs.svh"

module dptl_timecode #(
	parameter int CLK_HZ = `DPTL_CLK_HZ,
	parameter int TICK_HZ = `DPTL_TICK_HZ,
	parameter int SLOT_TC = `DPTL_SLOT_TC,
	parameter int NUM_SLOTS = `DPTL_NUM_SLOTS
) (
	input wire logic sys_clk,
	input wire logic rstn,
	output logic tick_q,
	output dptl_pkg::dptl_pos_t tc_pos_q,
	output logic wave_a_q,
	output logic wave_b_q
);
	localparam int STEP = TICK_HZ / `DPTL_RATE_GCD;
	localparam int MODV = CLK_HZ / `DPTL_RATE_GCD;
	localparam int AW = $clog2(MODV + STEP + 1);
	localparam int CW = $clog2(SLOT_TC + 1);
	localparam int SW = $clog2(NUM_SLOTS + 1);

	logic [AW-1:0] frac_q, frac_d;
	logic tick_d;
	dptl_pkg::dptl_pos_t tc_pos_d;
	logic [CW-1:0] cyc_q, cyc_d;
	logic [SW-1:0] slot_q, slot_d;
	logic wave_a_d, wave_b_d;

	// fractional divider: 50 MHz is not a whole multiple of 1.02 MHz, so the
	// pulse spacing jitters by one sys_clk while the average rate is exact
	always_comb begin
		logic [AW-1:0] sum;
		sum = frac_q + AW'(STEP);
		frac_d = sum;
		tick_d = 1'b0;
		tc_pos_d = tc_pos_q;
		cyc_d = cyc_q;
		slot_d = slot_q;
		if (sum >= AW'(MODV)) begin
			frac_d = sum - AW'(MODV);
			tick_d = 1'b1;
			if (tc_pos_q == 7'(`DPTL_TC_DIV - 1)) begin
				tc_pos_d = 7'h00;
				if (cyc_q == CW'(SLOT_TC - 1)) begin
					cyc_d = '0;
					slot_d = (slot_q == SW'(NUM_SLOTS - 1)) ? '0 : slot_q + SW'(1);
				end else begin
					cyc_d = cyc_q + CW'(1);
				end
			end else begin
				tc_pos_d = tc_pos_q + 7'h01;
			end
		end
		wave_a_d = (slot_d == SW'(`DPTL_SLOT_A));
		wave_b_d = (slot_d == SW'(`DPTL_SLOT_B));
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			frac_q <= '0;
			tick_q <= 1'b0;
			tc_pos_q <= 7'h00;
			cyc_q <= '0;
			slot_q <= '0;
			wave_a_q <= 1'b0;
			wave_b_q <= 1'b0;
		end else begin
			frac_q <= frac_d;
			tick_q <= tick_d;
			tc_pos_q <= tc_pos_d;
			cyc_q <= cyc_d;
			slot_q <= slot_d;
			wave_a_q <= wave_a_d;
			wave_b_q <= wave_b_d;
		end
	end
endmodule

// ### src/dptl_tracker.sv
/*
 * Digital phase tracking loop with two time-shared station registers,
 * optional tandem velocity integrators and a phase difference register.
 * Assumes limited_in is the hard-limited receive signal, synchronous to
 * sys_clk (50 MHz), and that multiplex alignment is handled elsewhere.
 */
`timescale 1ns/1ps
`include "dptl_regs.svh"

module dptl_tracker #(
	parameter int LOOP_ORDER = 2,
	parameter int VEL_W = 16,
	parameter int SLOT_TC = `DPTL_SLOT_TC,
	parameter int NUM_SLOTS = `DPTL_NUM_SLOTS
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic limited_in,
	output logic sample_q,
	output dptl_pkg::dptl_pos_t phase_ind_a_q,
	output dptl_pkg::dptl_pos_t phase_ind_b_q,
	output logic signed [7:0] phase_diff_q,
	output logic wave_a_q,
	output logic wave_b_q
);
	localparam int NV = LOOP_ORDER - 1;
	localparam int NVA = (NV > 0) ? NV : 1;

	logic tick_q;
	dptl_pkg::dptl_pos_t tc_pos_q;
	dptl_pkg::dptl_phase_t phase_q [2];
	dptl_pkg::dptl_phase_t phase_d [2];
	logic signed [VEL_W-1:0] vel_q [2][NVA];
	logic signed [VEL_W-1:0] vel_d [2][NVA];
	dptl_pkg::dptl_pos_t pos_a, pos_b, sel_pos;
	dptl_pkg::dptl_pos_t ind_a_d, ind_b_d;
	logic hit, sample_d, add_slot;
	logic signed [VEL_W-1:0] vstep;
	dptl_pkg::dptl_diff_step_t df_q, df_d;
	logic signed [7:0] dacc_q, dacc_d, diff_d;

	// phase register value modulo five decimal places
	function automatic dptl_pkg::dptl_phase_t ph_wrap(input dptl_pkg::dptl_phase_t v,
			input logic signed [31:0] d);
		logic signed [31:0] s;
		s = $signed({15'h0000, v}) + d;
		if (s < 0)
			s = s + `DPTL_PH_MOD;
		else if (s >= `DPTL_PH_MOD)
			s = s - `DPTL_PH_MOD;
		return s[16:0];
	endfunction

	// the two top decimal digits select the clock position
	function automatic dptl_pkg::dptl_pos_t pos_of(input dptl_pkg::dptl_phase_t v);
		return 7'(v / 17'(`DPTL_PH_DIGIT));
	endfunction

	dptl_timecode #(
		.SLOT_TC(SLOT_TC),
		.NUM_SLOTS(NUM_SLOTS)
	) u_tc (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.tick_q(tick_q),
		.tc_pos_q(tc_pos_q),
		.wave_a_q(wave_a_q),
		.wave_b_q(wave_b_q)
	);

	// sampling: the active station steers the matrix
	always_comb begin
		pos_a = pos_of(phase_q[0]);
		pos_b = pos_of(phase_q[1]);
		sel_pos = wave_b_q ? pos_b : pos_a;
		hit = tick_q && (wave_a_q || wave_b_q) && (tc_pos_q == sel_pos);
		sample_d = hit;
		vstep = limited_in ? VEL_W'(1) : -VEL_W'(1);
		add_slot = tick_q && (tc_pos_q == 7'(`DPTL_ADD_POS));
		ind_a_d = pos_a;
		ind_b_d = pos_b;
	end

	// loop integrators, gated per station
	always_comb begin
		logic gate;
		gate = 1'b0;
		phase_d = phase_q;
		vel_d = vel_q;
		for (int s = 0; s < 2; s++) begin
			gate = (s == 0) ? wave_a_q : wave_b_q;
			if (gate) begin
				if (NV == 0) begin
					if (hit)
						phase_d[s] = ph_wrap(phase_q[s], 32'(vstep));
				end else begin
					if (hit)
						vel_d[s][0] = vel_q[s][0] + vstep;
					if (add_slot) begin
						for (int k = 1; k < NVA; k++)
							vel_d[s][k] = vel_q[s][k] + vel_q[s][k-1];
						phase_d[s] = ph_wrap(phase_q[s], 32'(vel_q[s][NVA-1]));
					end
				end
			end
		end
	end

	// difference register: clear, add first station, subtract second
	always_comb begin
		df_d = df_q;
		dacc_d = dacc_q;
		diff_d = phase_diff_q;
		if (tick_q) begin
			case (df_q)
				dptl_pkg::DPTL_DF_IDLE: begin
					if (tc_pos_q == 7'(`DPTL_DIFF_POS))
						df_d = dptl_pkg::DPTL_DF_CLEAR;
				end
				dptl_pkg::DPTL_DF_CLEAR: begin
					dacc_d = 8'sh00;
					df_d = dptl_pkg::DPTL_DF_ADD;
				end
				dptl_pkg::DPTL_DF_ADD: begin
					dacc_d = dacc_q + $signed({1'b0, pos_a});
					df_d = dptl_pkg::DPTL_DF_SUB;
				end
				dptl_pkg::DPTL_DF_SUB: begin
					dacc_d = dacc_q - $signed({1'b0, pos_b});
					diff_d = dacc_d;
					df_d = dptl_pkg::DPTL_DF_IDLE;
				end
				default: df_d = dptl_pkg::DPTL_DF_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			for (int s = 0; s < 2; s++) begin
				phase_q[s] <= 17'(`DPTL_RST_VAL);
				for (int k = 0; k < NVA; k++)
					vel_q[s][k] <= VEL_W'(`DPTL_RST_VAL);
			end
			sample_q <= 1'b0;
			phase_ind_a_q <= 7'h00;
			phase_ind_b_q <= 7'h00;
			df_q <= dptl_pkg::DPTL_DF_IDLE;
			dacc_q <= 8'sh00;
			phase_diff_q <= 8'sh00;
		end else begin
			phase_q <= phase_d;
			vel_q <= vel_d;
			sample_q <= sample_d;
			phase_ind_a_q <= ind_a_d;
			phase_ind_b_q <= ind_b_d;
			df_q <= df_d;
			dacc_q <= dacc_d;
			phase_diff_q <= diff_d;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	tc_divide_a: assert property (tick_q && tc_pos_q == 7'h63 |=>
		!tick_q ##[1:60] (tick_q && tc_pos_q == 7'h00))
		else $error("time code did not wrap after position 99");
	tc_range_a: assert property (tc_pos_q < 7'h64)
		else $error("time code position out of range");
	sample_pos_a: assert property (sample_q |-> $past(tc_pos_q) == $past(sel_pos)
		&& $past(tick_q))
		else $error("sample pulse at wrong clock position");
	first_order_a: assert property (NV == 0 && hit && wave_a_q |=>
		phase_q[0] == ph_wrap($past(phase_q[0]), $past(limited_in) ? 32'sh1 : -32'sh1))
		else $error("sample not summed with its sign");
	vel_count_a: assert property (NV > 0 && hit && wave_a_q |=>
		vel_q[0][0] == $past(vel_q[0][0]) + ($past(limited_in) ? VEL_W'(1) : -VEL_W'(1)))
		else $error("velocity register missed a sample");
	vel_add_a: assert property (NV > 0 && add_slot && wave_a_q |=>
		phase_q[0] == ph_wrap($past(phase_q[0]), 32'($past(vel_q[0][NVA-1]))))
		else $error("velocity not added into phase register");
	gate_hold_a: assert property (!wave_b_q ##1 !wave_b_q |-> $stable(phase_q[1])
		&& $stable(vel_q[1][0]))
		else $error("idle station register changed");
	wave_excl_a: assert property (!(wave_a_q && wave_b_q))
		else $error("both station waveforms active");
	indicator_a: assert property (phase_ind_a_q == $past(pos_a))
		else $error("indicator does not follow register digits");
	diff_seq_a: assert property (tick_q && df_q == dptl_pkg::DPTL_DF_SUB |=>
		phase_diff_q == $past(dacc_q) - $signed({1'b0, $past(pos_b)}))
		else $error("difference register result wrong");

	cov_sample_a_c: cover property (hit && wave_a_q);
	cov_sample_b_c: cover property (hit && wave_b_q);
	cov_diff_c: cover property (tick_q && df_q == dptl_pkg::DPTL_DF_SUB);
	cov_vel_add_c: cover property (NV > 0 && add_slot && wave_b_q);
endmodule

// ### verif/dptl_limiter_model.sv
/*
 * Amplifier-limiter model: squared receive signal, one level per station.
 * Assumes the tracker's multiplex waveforms mark the station slots.
 */
`timescale 1ns/1ps

module dptl_limiter_model (
	input wire logic sys_clk,
	input wire logic wave_a_q,
	input wire logic wave_b_q,
	input wire logic pol_a,
	input wire logic pol_b,
	output logic limited_in
);
	integer seed = 72902;

	initial limited_in = 1'b0;

	// between transmissions only noise reaches the limiter, never a held level
	always @(posedge sys_clk) begin
		if (wave_a_q)
			limited_in <= pol_a;
		else if (wave_b_q)
			limited_in <= pol_b;
		else
			limited_in <= 1'($random(seed));
	end
endmodule

// ### verif/tb_dptl_tracker.sv
/*
 * Self-checking bench for the two-station tracker, first order and a third-order copy.
 * Assumes short slots (SLOT_TC 3, three slots) so the run stays brief.
 */
`timescale 1ns/1ps

module tb_dptl_tracker;
	typedef struct {logic is_b; int lo; int hi;} dptl_note_t;
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	logic pol_a = 1'b0;
	logic pol_b = 1'b0;
	logic limited_in, sample_q, wave_a_q, wave_b_q;
	logic prev_a = 1'b0;
	logic prev_b = 1'b0;
	dptl_pkg::dptl_pos_t phase_ind_a_q, phase_ind_b_q;
	logic signed [7:0] phase_diff_q;
	logic s3_sample, s3_wave_a, s3_wave_b;
	dptl_pkg::dptl_pos_t s3_ind_a, s3_ind_b;
	logic signed [7:0] s3_diff;
	int s3_cnt = 0;
	int bad_count = 0;
	int n_checks = 0;
	int slot_cnt = 0;
	dptl_note_t notes[$];
	dptl_note_t nt;

	always #10 sys_clk = ~sys_clk;

	dptl_tracker #(.LOOP_ORDER(1), .SLOT_TC(3), .NUM_SLOTS(3)) u_dptl_tracker (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.limited_in(limited_in),
		.sample_q(sample_q),
		.phase_ind_a_q(phase_ind_a_q),
		.phase_ind_b_q(phase_ind_b_q),
		.phase_diff_q(phase_diff_q),
		.wave_a_q(wave_a_q),
		.wave_b_q(wave_b_q)
	);

	// third-order copy on the same input: exercises the tandem velocity stages
	dptl_tracker #(.LOOP_ORDER(3), .SLOT_TC(3), .NUM_SLOTS(3)) u_dptl_tracker_o3 (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.limited_in(limited_in),
		.sample_q(s3_sample),
		.phase_ind_a_q(s3_ind_a),
		.phase_ind_b_q(s3_ind_b),
		.phase_diff_q(s3_diff),
		.wave_a_q(s3_wave_a),
		.wave_b_q(s3_wave_b)
	);

	dptl_limiter_model u_dptl_limiter_model (
		.sys_clk(sys_clk),
		.wave_a_q(wave_a_q),
		.wave_b_q(wave_b_q),
		.pol_a(pol_a),
		.pol_b(pol_b),
		.limited_in(limited_in)
	);

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// samples per station slot are counted and matched against the oldest note
	always @(posedge sys_clk) begin
		if (!rstn) begin
			slot_cnt = 0;
			s3_cnt = 0;
		end else begin
			s3_cnt = s3_cnt + int'(s3_sample);
			if (sample_q)
				check({7'h00, wave_a_q | wave_b_q | prev_a | prev_b}, 8'h01);
			slot_cnt = slot_cnt + int'(sample_q);
			if ((prev_a && !wave_a_q) || (prev_b && !wave_b_q)) begin
				if (notes.size() == 0)
					check(8'h00, 8'h01);
				else begin
					nt = notes.pop_front();
					check({7'h00, prev_b}, {7'h00, nt.is_b});
					check({7'h00, slot_cnt >= nt.lo && slot_cnt <= nt.hi}, 8'h01);
				end
				slot_cnt = 0;
			end
		end
		prev_a = wave_a_q;
		prev_b = wave_b_q;
	end

	task automatic wait_fall(input logic is_b);
		logic seen;
		seen = 1'b0;
		for (int i = 0; i < 30000; i++) begin
			@(negedge sys_clk);
			if (is_b ? wave_b_q : wave_a_q)
				seen = 1'b1;
			else if (seen)
				return;
		end
		bad_count++;
	endtask

	// the first sample of a B slot still sees the A level, since the limiter
	// answers one cycle late; the exact slot counts below include it
	task automatic run_phase(input logic pa, input logic pb, input int n_a,
			input int ca, input int cb, input logic [7:0] ea, input logic [7:0] eb,
			input logic [7:0] ed, input int n3, input logic [7:0] ea3,
			input logic [7:0] eb3, input logic [1:0] ew);
		@(posedge sys_clk);
		rstn <= 1'b0;
		pol_a <= pa;
		pol_b <= pb;
		repeat (6) @(posedge sys_clk);
		@(negedge sys_clk);
		check({sample_q, phase_ind_a_q}, 8'h00);
		check({wave_a_q, phase_ind_b_q}, 8'h00);
		check(phase_diff_q, 8'h00);
		check({s3_sample, s3_ind_a}, 8'h00);
		check({s3_wave_b, s3_ind_b}, 8'h00);
		for (int i = 0; i < n_a; i++) begin
			notes.push_back('{1'b0, ca, ca});
			if (i == 0)
				notes.push_back('{1'b1, cb, cb});
		end
		@(posedge sys_clk);
		rstn <= 1'b1;
		wait_fall(1'b0);
		wait_fall(1'b1);
		if (n_a > 1)
			wait_fall(1'b0);
		repeat (300) @(negedge sys_clk);
		check({1'b0, phase_ind_a_q}, ea);
		check({1'b0, phase_ind_b_q}, eb);
		check(phase_diff_q, ed);
		check({1'b0, s3_ind_a}, ea3);
		check({1'b0, s3_ind_b}, eb3);
		check(s3_diff, ea3 - eb3);
		check(8'(s3_cnt), 8'(n3));
		check({6'h00, wave_a_q, wave_b_q}, {6'h00, ew});
		check({6'h00, s3_wave_a, s3_wave_b}, {6'h00, ew});
		$display("test with levels %b %b end", pa, pb);
	endtask

	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		run_phase(1'b0, 1'b1, 2, 3, 4, 8'h63, 8'h00, 8'h63, 8, 8'h63, 8'h63, 2'b01);
		run_phase(1'b1, 1'b0, 1, 2, 4, 8'h00, 8'h63, 8'h9D, 5, 8'h00, 8'h00, 2'b00);
		check({7'h00, notes.size() == 0}, 8'h01);
		complete_run();
	end

	initial begin
		repeat (99000) @(posedge sys_clk);
		bad_count++;
		complete_run();
	end
endmodule
